// ==== rtl/pmw_power_wake.sv ====
`timescale 1ns/10ps

// What this block does
// - wake-frame flag sets, held until W1C
// - magic-packet flag sets, cleared only W1C
// - link-up flag sets, cleared by W1C
// - energy flag sets, cleared by W1C
// - mode field selects normal/energy/soft-down
// - polarity bit picks pin level, default low
// - wake-frame enable gates pin assertion
// - magic-packet enable gates pin assertion
// - link-up enable gates pin assertion
// - energy enable gates pin assertion
// - sleep only after go-sleep units without energy
module pmw_power_wake #(
    parameter int SLEEP_UNIT_CYCLES = pmw_pkg::PMW_SLEEP_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic [1:0] regByteEn,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    output logic regRdValid,
    input wire logic wakeFrameDet,
    input wire logic [1:0] magicPacketDet,
    input wire logic [1:0] linkUpDet,
    input wire logic [1:0] energyDet,
    output logic powerEventPin,
    output logic lowPowerState,
    output logic softPowerDown
);

    pmw_pkg::pmw_state_t s_reg;
    pmw_pkg::pmw_state_t s_next;
    logic [3:0] events;
    logic energyAny;
    logic wrLow;
    logic [3:0] clearMask;

    pmw_sleep_if sleepIf ();

    function automatic logic regHit(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        regHit = (addr == ofs);
    endfunction

    function automatic logic pinLevel(
        input logic [3:0] flags,
        input logic [4:0] enables
    );
        logic active;
        active = |(flags & enables[3:0]);
        pinLevel = active ? enables[pmw_pkg::PMW_POLARITY_BIT]
                          : !enables[pmw_pkg::PMW_POLARITY_BIT];
    endfunction

    assign energyAny = |energyDet;
    assign events[pmw_pkg::PMW_EV_WAKE] = wakeFrameDet;
    assign events[pmw_pkg::PMW_EV_MAGIC] = |magicPacketDet;
    assign events[pmw_pkg::PMW_EV_LINK] = |linkUpDet;
    assign events[pmw_pkg::PMW_EV_ENERGY] = energyAny;
    assign wrLow = regWrite && regByteEn[0];

    always_comb begin
        s_next = s_reg;
        s_next.rdValid = 1'b0;
        clearMask = 4'h0;
        if (wrLow && regHit(regAddr, pmw_pkg::PMW_OFS_MODE_STATUS)) begin
            clearMask = regWrData[pmw_pkg::PMW_FLAG_LSB +: 4];
            // reserved mode code is refused, mode keeps its value
            if (regWrData[1:0] != pmw_pkg::PMW_MODE_RESERVED) begin
                s_next.mode = regWrData[pmw_pkg::PMW_MODE_LSB +: 2];
            end
        end
        if (wrLow && regHit(regAddr, pmw_pkg::PMW_OFS_PIN_ENABLE)) begin
            s_next.enables = regWrData[pmw_pkg::PMW_ENABLE_W-1:0];
        end
        if (wrLow && regHit(regAddr, pmw_pkg::PMW_OFS_SLEEP_DELAY)) begin
            s_next.delay = regWrData[7:0];
        end
        // a new event wins over a clear in the same cycle
        s_next.flags = (s_reg.flags & ~clearMask)
            | events;
        // pin follows enabled flags, polarity applied last
        s_next.pin = pinLevel(s_reg.flags,
                              s_reg.enables);
        s_next.softDown = (s_reg.mode == pmw_pkg::PMW_MODE_SOFT_DOWN);
        if (regRead) begin
            s_next.rdValid = 1'b1;
            s_next.rdData = 16'h0000;
            if (regHit(regAddr, pmw_pkg::PMW_OFS_MODE_STATUS)) begin
                s_next.rdData[pmw_pkg::PMW_MODE_LSB +: 2] = s_reg.mode;
                s_next.rdData[pmw_pkg::PMW_FLAG_LSB +: 4] = s_reg.flags;
            end else if (regHit(regAddr, pmw_pkg::PMW_OFS_PIN_ENABLE)) begin
                s_next.rdData[pmw_pkg::PMW_ENABLE_W-1:0] = s_reg.enables;
            end else if (regHit(regAddr, pmw_pkg::PMW_OFS_SLEEP_DELAY)) begin
                s_next.rdData[7:0] = s_reg.delay;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_reg <= pmw_pkg::PMW_STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // absence timer runs only in energy-detect mode with no line energy
    assign sleepIf.armed = (s_reg.mode == pmw_pkg::PMW_MODE_ENERGY)
                           && !energyAny;
    assign sleepIf.delay = s_reg.delay;

    pmw_sleep_timer #(
        .UNIT_CYCLES(SLEEP_UNIT_CYCLES)
    ) u_sleep_timer (
        .clk(clk),
        .resetn(resetn),
        .sleepIf(sleepIf)
    );

    assign regRdData = s_reg.rdData;
    assign regRdValid = s_reg.rdValid;
    assign powerEventPin = s_reg.pin;
    assign lowPowerState = sleepIf.lowPower;
    assign softPowerDown = s_reg.softDown;

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!resetn);

    logic flagClearWr;
    assign flagClearWr = wrLow
                         && regHit(regAddr, pmw_pkg::PMW_OFS_MODE_STATUS);
    logic enableWr;
    assign enableWr = wrLow && regHit(regAddr, pmw_pkg::PMW_OFS_PIN_ENABLE);
    logic delayWr;
    assign delayWr = wrLow && regHit(regAddr, pmw_pkg::PMW_OFS_SLEEP_DELAY);
    logic statusRd;
    assign statusRd = regRead && regHit(regAddr, pmw_pkg::PMW_OFS_MODE_STATUS);

    a_wake_flag_set: assert property (
        wakeFrameDet |=> s_reg.flags[pmw_pkg::PMW_EV_WAKE])
        else $error("wake-frame flag not set by event");

    a_wake_flag_hold: assert property (
        s_reg.flags[pmw_pkg::PMW_EV_WAKE]
        && !(flagClearWr && regWrData[5])
        |=> s_reg.flags[pmw_pkg::PMW_EV_WAKE])
        else $error("wake-frame flag dropped without clear");

    a_magic_flag_set: assert property (
        |magicPacketDet |=> s_reg.flags[pmw_pkg::PMW_EV_MAGIC])
        else $error("magic-packet flag not set by event");

    a_magic_flag_hold: assert property (
        s_reg.flags[pmw_pkg::PMW_EV_MAGIC]
        && !(flagClearWr && regWrData[4])
        |=> s_reg.flags[pmw_pkg::PMW_EV_MAGIC])
        else $error("magic-packet flag dropped without clear");

    a_link_flag_set: assert property (
        |linkUpDet |=> s_reg.flags[pmw_pkg::PMW_EV_LINK])
        else $error("link-up flag not set by event");

    a_link_flag_clear: assert property (
        flagClearWr && regWrData[3] && !(|linkUpDet)
        |=> !s_reg.flags[pmw_pkg::PMW_EV_LINK])
        else $error("link-up flag not cleared by write of one");

    a_energy_flag_set: assert property (
        energyAny |=> s_reg.flags[pmw_pkg::PMW_EV_ENERGY])
        else $error("energy flag not set by event");

    a_mode_reserved: assert property (
        s_reg.mode != pmw_pkg::PMW_MODE_RESERVED)
        else $error("reserved power mode stored");

    a_soft_down_out: assert property (
        s_reg.mode == pmw_pkg::PMW_MODE_SOFT_DOWN ##1
        s_reg.mode == pmw_pkg::PMW_MODE_SOFT_DOWN |-> softPowerDown)
        else $error("soft power-down not shown for mode");

    a_pin_idle_level: assert property (
        !(|(s_reg.flags & s_reg.enables[3:0]))
        |=> powerEventPin == !$past(s_reg.enables[pmw_pkg::PMW_POLARITY_BIT]))
        else $error("pin not at inactive level");

    a_wake_pin: assert property (
        s_reg.flags[pmw_pkg::PMW_EV_WAKE]
        && s_reg.enables[pmw_pkg::PMW_EV_WAKE]
        |=> powerEventPin == $past(s_reg.enables[pmw_pkg::PMW_POLARITY_BIT]))
        else $error("enabled wake frame did not assert pin");

    a_magic_pin: assert property (
        s_reg.flags[pmw_pkg::PMW_EV_MAGIC]
        && s_reg.enables[pmw_pkg::PMW_EV_MAGIC]
        |=> powerEventPin == $past(s_reg.enables[pmw_pkg::PMW_POLARITY_BIT]))
        else $error("enabled magic packet did not assert pin");

    a_link_pin: assert property (
        s_reg.flags[pmw_pkg::PMW_EV_LINK]
        && s_reg.enables[pmw_pkg::PMW_EV_LINK]
        |=> powerEventPin == $past(s_reg.enables[pmw_pkg::PMW_POLARITY_BIT]))
        else $error("enabled link-up did not assert pin");

    a_energy_pin: assert property (
        s_reg.flags[pmw_pkg::PMW_EV_ENERGY]
        && s_reg.enables[pmw_pkg::PMW_EV_ENERGY]
        |=> powerEventPin == $past(s_reg.enables[pmw_pkg::PMW_POLARITY_BIT]))
        else $error("enabled energy detect did not assert pin");

    a_sleep_mode_only: assert property (
        s_reg.mode != pmw_pkg::PMW_MODE_ENERGY ##1
        s_reg.mode != pmw_pkg::PMW_MODE_ENERGY |-> !lowPowerState)
        else $error("low power outside energy-detect mode");

    a_pin_release: assert property (
        (!(|(s_reg.flags & s_reg.enables[3:0])))[*2]
        |-> powerEventPin == !s_reg.enables[pmw_pkg::PMW_POLARITY_BIT]
            || $changed(s_reg.enables))
        else $error("pin held after enabled flags cleared");

    a_read_answer: assert property (
        regRead |=> regRdValid)
        else $error("read gave no answer next cycle");

    a_read_status: assert property (
        statusRd |=> regRdData == {10'h000, $past(s_reg.flags),
            $past(s_reg.mode)})
        else $error("status read returned wrong value");

    a_read_pulse: assert property (
        !regRead |=> !regRdValid)
        else $error("read answer without read strobe");

    a_wake_flag_clear: assert property (
        flagClearWr && regWrData[5] && !wakeFrameDet
        |=> !s_reg.flags[pmw_pkg::PMW_EV_WAKE])
        else $error("wake-frame flag not cleared by write of one");

    a_magic_flag_clear: assert property (
        flagClearWr && regWrData[4] && !(|magicPacketDet)
        |=> !s_reg.flags[pmw_pkg::PMW_EV_MAGIC])
        else $error("magic-packet flag not cleared by write of one");

    a_link_flag_hold: assert property (
        s_reg.flags[pmw_pkg::PMW_EV_LINK]
        && !(flagClearWr && regWrData[3])
        |=> s_reg.flags[pmw_pkg::PMW_EV_LINK])
        else $error("link-up flag dropped without clear");

    a_energy_flag_hold: assert property (
        s_reg.flags[pmw_pkg::PMW_EV_ENERGY]
        && !(flagClearWr && regWrData[2])
        |=> s_reg.flags[pmw_pkg::PMW_EV_ENERGY])
        else $error("energy flag dropped without clear");

    a_energy_flag_clear: assert property (
        flagClearWr && regWrData[2] && !energyAny
        |=> !s_reg.flags[pmw_pkg::PMW_EV_ENERGY])
        else $error("energy flag not cleared by write of one");

    a_mode_write: assert property (
        flagClearWr && regWrData[1:0] != pmw_pkg::PMW_MODE_RESERVED
        |=> s_reg.mode == $past(regWrData[1:0]))
        else $error("power mode not taken from write");

    a_mode_refused: assert property (
        flagClearWr && regWrData[1:0] == pmw_pkg::PMW_MODE_RESERVED
        |=> $stable(s_reg.mode))
        else $error("reserved power mode write changed mode");

    a_soft_down_off: assert property (
        s_reg.mode != pmw_pkg::PMW_MODE_SOFT_DOWN ##1
        s_reg.mode != pmw_pkg::PMW_MODE_SOFT_DOWN |-> !softPowerDown)
        else $error("soft power-down shown outside its mode");

    a_enable_write: assert property (
        enableWr
        |=> s_reg.enables == $past(regWrData[pmw_pkg::PMW_ENABLE_W-1:0]))
        else $error("enable and polarity bits not taken from write");

    a_low_byte_gate: assert property (
        regWrite && !regByteEn[0]
        |=> $stable(s_reg.mode) && $stable(s_reg.enables)
            && $stable(s_reg.delay))
        else $error("write without low byte enable changed a register");

    a_delay_write: assert property (
        delayWr |=> s_reg.delay == $past(regWrData[7:0]))
        else $error("go-sleep count not taken from write");

    a_sleep_energy_exit: assert property (
        energyAny |=> !lowPowerState)
        else $error("low power kept while line energy present");

    c_wake_pin_on: cover property (
        wakeFrameDet && s_reg.enables[pmw_pkg::PMW_EV_WAKE] ##2
        powerEventPin == s_reg.enables[pmw_pkg::PMW_POLARITY_BIT]);

    c_flag_cleared: cover property (
        s_reg.flags[pmw_pkg::PMW_EV_LINK] ##1
        !s_reg.flags[pmw_pkg::PMW_EV_LINK]);

    c_set_over_clear: cover property (
        flagClearWr && regWrData[5] && wakeFrameDet);

    c_soft_down: cover property ($rose(softPowerDown));

endmodule // pmw_power_wake

// ==== rtl/pmw_pkg.sv ====
package pmw_pkg;

    // register offsets on the host bus (byte addresses)
    localparam logic [7:0] PMW_OFS_MODE_STATUS = 8'h32;
    localparam logic [7:0] PMW_OFS_PIN_ENABLE = 8'h34;
    localparam logic [7:0] PMW_OFS_SLEEP_DELAY = 8'h36;

    // power_mode_and_wake_status fields
    localparam int PMW_MODE_LSB = 0;
    localparam int PMW_FLAG_LSB = 2;
    localparam int PMW_FLAG_W = 4;

    // flag and enable index: 0 energy, 1 link-up, 2 magic, 3 wake frame
    localparam int PMW_EV_ENERGY = 0;
    localparam int PMW_EV_LINK = 1;
    localparam int PMW_EV_MAGIC = 2;
    localparam int PMW_EV_WAKE = 3;
    localparam int PMW_POLARITY_BIT = 4;
    localparam int PMW_ENABLE_W = 5;

    typedef enum logic [1:0] {
        PMW_MODE_NORMAL = 2'h0,
        PMW_MODE_ENERGY = 2'h1,
        PMW_MODE_SOFT_DOWN = 2'h2,
        PMW_MODE_RESERVED = 2'h3
    } pmw_mode_t;

    // values after reset
    localparam logic [1:0] PMW_MODE_RST = 2'h0;
    localparam logic [3:0] PMW_FLAGS_RST = 4'h0;
    localparam logic [4:0] PMW_ENABLE_RST = 5'h00;
    localparam logic [7:0] PMW_DELAY_RST = 8'h8E;
    localparam logic PMW_PIN_RST = 1'b1;

    // go-sleep unit time
    localparam int PMW_SLEEP_UNIT_MS = 20;
    localparam int PMW_CLK_HZ = 10000000;
    localparam int PMW_SLEEP_UNIT_CYCLES =
        PMW_SLEEP_UNIT_MS * (PMW_CLK_HZ / 1000);
    localparam int PMW_PRESCALE_W = 18;

    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] flags;
        logic [4:0] enables;
        logic [7:0] delay;
        logic pin;
        logic softDown;
        logic [15:0] rdData;
        logic rdValid;
    } pmw_state_t;

    localparam pmw_state_t PMW_STATE_RST = '{
        mode: PMW_MODE_RST,
        flags: PMW_FLAGS_RST,
        enables: PMW_ENABLE_RST,
        delay: PMW_DELAY_RST,
        pin: PMW_PIN_RST,
        softDown: 1'b0,
        rdData: 16'h0000,
        rdValid: 1'b0
    };

    typedef struct packed {
        logic [17:0] prescale;
        logic [7:0] units;
        logic lowPower;
    } pmw_timer_t;

    localparam pmw_timer_t PMW_TIMER_RST = '{
        prescale: 18'h00000,
        units: 8'h00,
        lowPower: 1'b0
    };

endpackage

// ==== rtl/pmw_sleep_if.sv ====
`timescale 1ns/10ps

interface pmw_sleep_if;
    logic armed;
    logic [7:0] delay;
    logic lowPower;

    modport ctrl (
        output armed,
        output delay,
        input lowPower
    );

    modport timer (
        input armed,
        input delay,
        output lowPower
    );
endinterface

// ==== rtl/pmw_sleep_timer.sv ====
`timescale 1ns/10ps

module pmw_sleep_timer #(
    parameter int UNIT_CYCLES = pmw_pkg::PMW_SLEEP_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    pmw_sleep_if.timer sleepIf
);

    pmw_pkg::pmw_timer_t st_reg;
    pmw_pkg::pmw_timer_t st_next;

    localparam logic [17:0] UNIT_LAST = 18'(UNIT_CYCLES - 1);

    // counts whole units of continuous absence of energy
    always_comb begin
        st_next = st_reg;
        if (!sleepIf.armed) begin
            st_next = pmw_pkg::PMW_TIMER_RST;
        end else if (st_reg.units >= sleepIf.delay) begin
            st_next.prescale = 18'h00000;
        end else if (st_reg.prescale == UNIT_LAST) begin
            st_next.prescale = 18'h00000;
            st_next.units = st_reg.units + 8'h01;
        end else begin
            st_next.prescale = st_reg.prescale + 18'h00001;
        end
        if (sleepIf.armed) begin
            st_next.lowPower = (st_reg.units >= sleepIf.delay);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg <= pmw_pkg::PMW_TIMER_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sleepIf.lowPower = st_reg.lowPower;

    a_sleep_disarm: assert property (
        @(posedge clk) disable iff (!resetn)
        !sleepIf.armed |=> !sleepIf.lowPower)
        else $error("low power held without armed absence");

    a_sleep_wait_done: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(sleepIf.lowPower)
        |-> $past(st_reg.units) >= $past(sleepIf.delay)
            && $past(sleepIf.armed))
        else $error("low power entered before go-sleep count");

    c_sleep_entry: cover property (@(posedge clk) disable iff (!resetn)
        $rose(sleepIf.lowPower));

endmodule // pmw_sleep_timer

// ==== test/pmw_wake_host.sv ====
`timescale 1ns/10ps

module pmw_wake_host (
    input wire logic clk,
    input wire logic powerEventPin,
    input wire logic activeHigh,
    output logic wakeFrameDet,
    output logic [1:0] magicPacketDet,
    output logic [1:0] linkUpDet,
    output logic [1:0] energyDet,
    output logic wakeSeen
);
    // host sees a wake request while the pin sits at its active level
    assign wakeSeen = (powerEventPin == activeHigh);

    initial begin
        wakeFrameDet = 1'b0;
        magicPacketDet = 2'h0;
        linkUpDet = 2'h0;
        energyDet = 2'h0;
    end

    // one-cycle event: 0 energy, 1 link-up, 2 magic, 3 wake frame
    task automatic pulse(input int kind, input int port);
        @(negedge clk);
        case (kind)
            0: energyDet[port] = 1'b1;
            1: linkUpDet[port] = 1'b1;
            2: magicPacketDet[port] = 1'b1;
            default: wakeFrameDet = 1'b1;
        endcase
        @(negedge clk);
        wakeFrameDet = 1'b0;
        magicPacketDet = 2'h0;
        linkUpDet = 2'h0;
        energyDet = 2'h0;
    endtask

    // line energy level on both ports
    task automatic setEnergy(input logic lvl);
        @(negedge clk);
        energyDet = {lvl, lvl};
    endtask
endmodule // pmw_wake_host

// ==== test/pmw_power_wake_test.sv ====
`timescale 1ns/10ps

module pmw_power_wake_test;
    typedef struct packed {
        logic [7:0] a;
        logic [1:0] b;
        logic [15:0] d;
        logic [15:0] e;
    } pmw_row_t;
    logic clk, resetn, regWrite, regRead, regRdValid, pol, wakeSeen;
    logic wakeFrameDet, powerEventPin, lowPowerState, softPowerDown;
    logic [7:0] regAddr;
    logic [15:0] regWrData, regRdData, rdv;
    logic [1:0] regByteEn, magicPacketDet, linkUpDet, energyDet;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    // address, byte enables, write data, expected read back
    pmw_row_t rows [9] = '{
        '{8'h34, 2'h3, 16'hFFFF, 16'h001F},
        '{8'h34, 2'h1, 16'h0000, 16'h0000},
        '{8'h36, 2'h3, 16'hFFFF, 16'h00FF},
        '{8'h36, 2'h1, 16'h0002, 16'h0002},
        '{8'h36, 2'h2, 16'h0055, 16'h0002},
        '{8'h32, 2'h1, 16'h0001, 16'h0001},
        '{8'h32, 2'h1, 16'h0003, 16'h0001},
        '{8'h32, 2'h1, 16'h0002, 16'h0002},
        '{8'h38, 2'h3, 16'hFFFF, 16'h0000}
    };

    pmw_power_wake #(.SLEEP_UNIT_CYCLES(4)) i_pmw_power_wake (
        .clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWrData(regWrData), .regByteEn(regByteEn),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .regRdValid(regRdValid), .wakeFrameDet(wakeFrameDet),
        .magicPacketDet(magicPacketDet), .linkUpDet(linkUpDet),
        .energyDet(energyDet), .powerEventPin(powerEventPin),
        .lowPowerState(lowPowerState), .softPowerDown(softPowerDown)
    );

    pmw_wake_host i_pmw_wake_host (
        .clk(clk), .powerEventPin(powerEventPin), .activeHigh(pol),
        .wakeFrameDet(wakeFrameDet), .magicPacketDet(magicPacketDet),
        .linkUpDet(linkUpDet), .energyDet(energyDet), .wakeSeen(wakeSeen)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk16(input string s, input logic [15:0] x,
                         input logic [15:0] y);
        cmp_count++;
        if (y !== x) begin
            err_count++;
            $display("wrong value %s exp %h got %h", s, x, y);
        end
    endtask

    task automatic chk1(input string s, input logic x, input logic y);
        cmp_count++;
        if (y !== x) begin
            err_count++;
            $display("wrong value %s exp %b got %b", s, x, y);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [1:0] b,
                      input logic [15:0] d);
        @(negedge clk);
        regAddr = a;
        regByteEn = b;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        chk1("rdValid", 1'b1, regRdValid);
        d = regRdData;
    endtask

    task automatic chkReset;
        chk1("pinRst", 1'b1, powerEventPin);
        chk1("lowRst", 1'b0, lowPowerState);
        chk1("softRst", 1'b0, softPowerDown);
        rd(8'h32, rdv);
        chk16("statusRst", 16'h0000, rdv);
        rd(8'h34, rdv);
        chk16("enableRst", 16'h0000, rdv);
        rd(8'h36, rdv);
        chk16("delayRst", 16'h008E, rdv);
    endtask

    initial begin
        resetn = 1'b0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWrData = 16'h0000;
        regByteEn = 2'h0;
        pol = 1'b0;
        tick(20);
        resetn = 1'b1;
        chkReset();
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].b, rows[i].d);
            rd(rows[i].a, rdv);
            chk16("regValue", rows[i].e, rdv);
            if (rows[i].a == 8'h32) begin
                chk1("softDown", rows[i].e[1:0] == 2'h2,
                     softPowerDown);
            end
        end
        wr(8'h32, 2'h1, 16'h0000);
        $display("test registers done");
        for (int e = 0; e < 4; e++) begin
            wr(8'h34, 2'h1, 16'h000F ^ (16'h0001 << e));
            i_pmw_wake_host.pulse(e, e % 2);
            tick(1);
            chk1("pinMasked", 1'b0, wakeSeen);
            rd(8'h32, rdv);
            chk16("flagSet", 16'h0004 << e, rdv);
            wr(8'h34, 2'h1, 16'h0001 << e);
            tick(1);
            chk1("pinActive", 1'b1, wakeSeen);
            wr(8'h32, 2'h1, 16'h0004 << e);
            tick(1);
            chk1("pinCleared", 1'b0, wakeSeen);
            rd(8'h32, rdv);
            chk16("flagClear", 16'h0000, rdv);
        end
        $display("test events done");
        i_pmw_wake_host.pulse(3, 0);
        fork
            wr(8'h32, 2'h1, 16'h0020);
            i_pmw_wake_host.pulse(3, 0);
        join
        rd(8'h32, rdv);
        chk16("eventWins", 16'h0020, rdv);
        $display("test collision done");
        pol = 1'b1;
        wr(8'h34, 2'h1, 16'h0018);
        tick(1);
        chk1("polActive", 1'b1, powerEventPin);
        wr(8'h32, 2'h1, 16'h0020);
        tick(1);
        chk1("polIdle", 1'b0, powerEventPin);
        $display("test polarity done");
        wr(8'h36, 2'h1, 16'h0002);
        wr(8'h32, 2'h1, 16'h0001);
        tick(6);
        chk1("earlySleep", 1'b0, lowPowerState);
        i_pmw_wake_host.setEnergy(1'b1);
        i_pmw_wake_host.setEnergy(1'b0);
        n = 0;
        while (lowPowerState !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk1("sleepTime", 1'b1, n >= 8 && n <= 14);
        i_pmw_wake_host.setEnergy(1'b1);
        tick(2);
        chk1("wakeOnEnergy", 1'b0, lowPowerState);
        i_pmw_wake_host.setEnergy(1'b0);
        wr(8'h32, 2'h1, 16'h0004);
        $display("test sleep done");
        wr(8'h34, 2'h1, 16'h001F);
        resetn = 1'b0;
        pol = 1'b0;
        tick(2);
        resetn = 1'b1;
        chkReset();
        $display("test second reset done");
        report_and_stop();
    end
endmodule // pmw_power_wake_test
